// File: dv/cbh_adapter_properties.sv
/* Port checker for the adapter. Assumes one clock and an active-low reset. */
`timescale 1ns/10ps
module cbh_adapter_properties (
    // Clock, reset and host side.
    input wire i_clk, i_reset_n, i_host_cmd_wr, i_host_cmd_rd,
    input wire i_host_flag_low, i_host_flag_high,
    // Adapter outputs.
    input wire o_host_cmd_full_flag, o_adapter_cmd_empty_flag, o_host_irq,
    input wire o_adapter_flag_low, o_adapter_flag_high, o_xfer_start,
    input wire [4:0] o_rx_mode,
    input wire [15:0] o_cmd_q_entries, o_pkt_buf_bytes, o_xfer_count,
    input wire [7:0] o_tx_buf_count
);
    // Every check samples on the rising edge and rests during reset.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);
    property p_full; i_host_cmd_wr |=> o_host_cmd_full_flag; endproperty
    a_full: assert property (p_full) else $error("full not set");
    property p_clr; $fell(o_host_cmd_full_flag) |-> !$past(i_host_cmd_wr); endproperty
    a_clr: assert property (p_clr) else $error("full lost a write");
    property p_empty; i_host_cmd_rd |=> o_adapter_cmd_empty_flag; endproperty
    a_empty: assert property (p_empty) else $error("empty not set");
    property p_irq; o_host_irq |-> !o_adapter_cmd_empty_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq with no byte");
    property p_fixed; o_pkt_buf_bytes == 16'h0640 && o_tx_buf_count == 8'h01; endproperty
    a_fixed: assert property (p_fixed) else $error("buffer sizes moved");
    property p_ans; $rose(o_adapter_flag_low) && !o_adapter_flag_high
        |-> $past(i_host_flag_low && i_host_flag_high); endproperty
    a_ans: assert property (p_ans) else $error("accept without end");
    property p_dflt; $rose(i_reset_n) |-> o_cmd_q_entries == 16'h000A
        && o_rx_mode == 5'h00; endproperty
    a_dflt: assert property (p_dflt) else $error("bad defaults");
    property p_even; o_xfer_start |-> ##[0:1] !o_xfer_count[0]; endproperty
    a_even: assert property (p_even) else $error("odd transfer");
endmodule
bind cbh_adapter cbh_adapter_properties cbh_adapter_properties_i (.i_clk, .i_reset_n,
    .i_host_cmd_wr, .i_host_cmd_rd, .i_host_flag_low, .i_host_flag_high,
    .o_host_cmd_full_flag, .o_adapter_cmd_empty_flag, .o_host_irq, .o_adapter_flag_low,
    .o_adapter_flag_high, .o_xfer_start, .o_rx_mode, .o_cmd_q_entries, .o_pkt_buf_bytes,
    .o_xfer_count, .o_tx_buf_count);

// File: dv/cbh_host_model.sv
/* Host driver model. Assumes the adapter samples on the rising edge. */
`timescale 1ns/10ps
module cbh_host_model (
    // Clock and adapter outputs.
    input wire i_clk, i_full, i_empty,
    input wire [7:0] i_cmd_data,
    input wire [1:0] i_aflags,
    // Host drives, changed at falling edges.
    output logic o_wr = 1'b0,
    output logic [7:0] o_data = 8'h00,
    output logic o_rd = 1'b0,
    output logic [1:0] o_flags = 2'h0,
    output logic o_dir = 1'b0
);
    // Writes one byte once the register is empty; the bus then shows junk.
    task automatic put(input logic [7:0] b);
        @(negedge i_clk);
        for (int t = 0; i_full && t < 5000; t++) @(negedge i_clk);
        o_wr = 1'b1;
        o_data = b;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_data = ~b;
    endtask
    // Sends a block, marks its end, then waits a bounded time for the answer.
    task automatic send(input logic [7:0] q[$], output logic [1:0] ans);
        foreach (q[k]) put(q[k]);
        o_flags = 2'h3;
        put(8'(q.size()));
        for (int t = 0; i_aflags inside {2'h0, 2'h3} && t < 500; t++) @(negedge i_clk);
        ans = i_aflags;
        @(negedge i_clk);
        o_flags = 2'h0;
    endtask
    // Reads a response block and accepts it once the end byte is seen.
    task automatic recv(output logic [7:0] r[$]);
        logic last;
        r = {};
        last = 1'b0;
        for (int t = 0; !last && t < 5000; t++) begin
            @(negedge i_clk);
            if (!i_empty) begin
                r.push_back(i_cmd_data);
                last = (i_aflags == 2'h3);
                o_rd = 1'b1;
                @(negedge i_clk);
                o_rd = 1'b0;
            end
        end
        o_flags = 2'h1;
        for (int t = 0; i_aflags != 2'h0 && t < 50; t++) @(negedge i_clk);
        @(negedge i_clk);
        o_flags = 2'h0;
    endtask
endmodule

// File: dv/test_command_block_handshake.sv
/* Self-checking bench for the adapter. Assumes the host model drives the host side. */
`timescale 1ns/10ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, a); end end
module test_command_block_handshake;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_pkt_rx = 1'b0;
    logic i_tx_done = 1'b0;
    logic [47:0] i_station_addr = 48'h5A6B7C8D9EAF;
    wire i_host_cmd_wr, i_host_cmd_rd, i_dir, o_host_cmd_full_flag, o_adapter_cmd_empty_flag;
    wire o_adapter_flag_low, o_adapter_flag_high, o_host_irq, o_xfer_start, o_xfer_upload;
    wire o_xfer_dma, o_xfer_error, o_send_abort;
    wire [1:0] hf;
    wire [4:0] o_rx_mode;
    wire [7:0] i_host_cmd_data, o_cmd_data, o_tx_buf_count;
    wire [15:0] o_cmd_q_entries, o_rx_q_entries, o_mcast_count, o_frame_count, o_xfer_count;
    wire [15:0] o_rx_buf_count, o_prog_count, o_pkt_buf_bytes;
    int err_total = 0;
    int samples_checked = 0;
    logic [7:0] r[$];
    logic [1:0] a;
    logic xerr = 1'b0;
    cbh_adapter cbh_adapter_i (.i_clk, .i_reset_n, .i_host_cmd_wr, .i_host_cmd_data,
        .i_host_cmd_rd, .i_host_flag_low(hf[0]), .i_host_flag_high(hf[1]), .i_dir, .i_pkt_rx,
        .i_tx_done, .i_station_addr, .o_cmd_data, .o_host_cmd_full_flag,
        .o_adapter_cmd_empty_flag, .o_adapter_flag_low, .o_adapter_flag_high, .o_host_irq,
        .o_rx_mode, .o_cmd_q_entries, .o_rx_q_entries, .o_mcast_count, .o_frame_count,
        .o_rx_buf_count, .o_prog_count, .o_pkt_buf_bytes, .o_tx_buf_count, .o_xfer_start,
        .o_xfer_upload, .o_xfer_dma, .o_xfer_count, .o_xfer_error, .o_send_abort);
    cbh_host_model cbh_host_model_i (.i_clk, .i_full(o_host_cmd_full_flag),
        .i_empty(o_adapter_cmd_empty_flag), .i_cmd_data(o_cmd_data),
        .i_aflags({o_adapter_flag_high, o_adapter_flag_low}), .o_wr(i_host_cmd_wr),
        .o_data(i_host_cmd_data), .o_rd(i_host_cmd_rd), .o_flags(hf), .o_dir(i_dir));
    // Free-running 100 MHz clock.
    always #5 i_clk = ~i_clk;
    // Remembers a refused transfer pulse for a later check.
    always @(posedge i_clk) begin
        if (o_xfer_error) xerr <= 1'b1;
    end
    // Sends a block and checks the adapter's answer code.
    task automatic blk(input logic [7:0] q[$], input logic [1:0] exp);
        cbh_host_model_i.send(q, a);
        `CHK("answer", exp, a)
    endtask
    // Reads a response and checks code, data length, size and closing length.
    task automatic rsp(input logic [7:0] code, input logic [7:0] dlen);
        cbh_host_model_i.recv(r);
        `CHK("code", code, r[0])
        `CHK("dlen", dlen, r[1])
        `CHK("total", dlen + 8'h02, r[r.size()-1])
        `CHK("size", dlen + 8'h03, 8'(r.size()))
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Cuts a hang short far beyond the few hundred cycles the tests need.
    initial begin
        #500000;
        err_total++;
        give_verdict();
    end
    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        `CHK("progs", 16'h000A, o_prog_count)
        `CHK("rx q", 16'h0014, o_rx_q_entries)
        `CHK("pkt buf", 16'h0640, o_pkt_buf_bytes)
        $display("reset test done");
        cbh_host_model_i.put(8'h77);
        blk('{8'h03, 8'h00}, 2'h1);
        rsp(8'h33, 8'h06);
        for (int k = 0; k < 6; k++) `CHK("addr", i_station_addr[8*k +: 8], r[k+2])
        blk('{8'h02, 8'h02, 8'h15, 8'h00}, 2'h1);
        rsp(8'h32, 8'h02);
        `CHK("rx mode", 5'h15, o_rx_mode)
        blk('{8'h01, 8'h0C, 8'h05, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00,
            8'h08, 8'h00, 8'h03, 8'h00}, 2'h1);
        rsp(8'h31, 8'h02);
        `CHK("progs", 16'h0003, o_prog_count)
        `CHK("mem cfg", 80'h00050006000000070008, {o_cmd_q_entries, o_rx_q_entries,
            o_mcast_count, o_frame_count, o_rx_buf_count})
        blk('{8'h03, 8'h05}, 2'h2);
        cbh_host_model_i.o_dir = 1'b1;
        blk('{8'h05, 8'h06, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2'h1);
        `CHK("upload", 18'h30010, {o_xfer_upload, o_xfer_dma, o_xfer_count})
        `CHK("no rsp", 1'b1, o_adapter_cmd_empty_flag)
        blk('{8'h04, 8'h06, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2'h1);
        `CHK("dir err", 1'b1, xerr)
        cbh_host_model_i.o_dir = 1'b0;
        blk('{8'h06, 8'h06, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2'h1);
        `CHK("download", 18'h00020, {o_xfer_upload, o_xfer_dma, o_xfer_count})
        $display("config and transfer tests done");
        blk('{8'h08, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00},
            2'h1);
        i_pkt_rx = 1'b1;
        @(negedge i_clk);
        i_pkt_rx = 1'b0;
        rsp(8'h38, 8'h02);
        `CHK("rx dma", 18'h30040, {o_xfer_upload, o_xfer_dma, o_xfer_count})
        blk('{8'h09, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00}, 2'h1);
        i_tx_done = 1'b1;
        @(negedge i_clk);
        i_tx_done = 1'b0;
        rsp(8'h39, 8'h02);
        $display("packet tests done");
        give_verdict();
    end
endmodule

// File: hdl/cbh_adapter.v
/*
 * Adapter end of the command block exchange. Takes host blocks through the
 * command register, checks them at end of block and answers with a
 * response block, keeping the adapter flag pair and timeouts.
 * Assumes host writes and reads of the command register arrive as single
 * cycle strobes synchronous to i_clk, and packet events as pulses.
 */
`timescale 1ns/10ps
`include "cbh_defines.vh"

module cbh_adapter (
    // Clock and reset.
    input wire i_clk,
    input wire i_reset_n,
    // Host side of the command register and flags.
    input wire i_host_cmd_wr,
    input wire [7:0] i_host_cmd_data,
    input wire i_host_cmd_rd,
    input wire i_host_flag_low,
    input wire i_host_flag_high,
    input wire i_dir,
    // Packet and transfer events from the datapath.
    input wire i_pkt_rx,
    input wire i_tx_done,
    input wire [47:0] i_station_addr,
    // Command register toward the host and flags.
    output reg [7:0] o_cmd_data,
    output reg o_host_cmd_full_flag,
    output reg o_adapter_cmd_empty_flag,
    output reg o_adapter_flag_low,
    output reg o_adapter_flag_high,
    output reg o_host_irq,
    // Configuration and data path control.
    output reg [4:0] o_rx_mode,
    output reg [15:0] o_cmd_q_entries,
    output reg [15:0] o_rx_q_entries,
    output reg [15:0] o_mcast_count,
    output reg [15:0] o_frame_count,
    output reg [15:0] o_rx_buf_count,
    output reg [15:0] o_prog_count,
    output reg [15:0] o_pkt_buf_bytes,
    output reg [7:0] o_tx_buf_count,
    output reg o_xfer_start,
    output reg o_xfer_upload,
    output reg o_xfer_dma,
    output reg [15:0] o_xfer_count,
    output reg o_xfer_error,
    output reg o_send_abort
);

    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_CHECK = 4'h1;
    localparam [3:0] ST_PARSE = 4'h2;
    localparam [3:0] ST_ACT = 4'h3;
    localparam [3:0] ST_WAIT_PKT = 4'h4;
    localparam [3:0] ST_SEND = 4'h5;
    localparam [3:0] ST_SEND_WAIT = 4'h6;
    localparam [3:0] ST_HOST_ANS = 4'h7;
    localparam [3:0] ST_HOLD = 4'h8;

    reg [3:0] state;
    reg [5:0] rd_back;
    wire [7:0] ring_data;
    reg [7:0] total_len;
    reg [5:0] idx;
    reg [7:0] blk [0:`CBH_MAX_BLOCK-1];
    reg [7:0] rsp [0:`CBH_MAX_BLOCK-1];
    reg [6:0] rsp_len;
    reg [6:0] send_idx;
    reg [21:0] tmo;
    reg [23:0] tick;
    reg [15:0] rx_ticks;
    reg [15:0] rx_limit;
    reg end_seen;
    reg [1:0] host_flags_prev;
    integer k;

    wire [1:0] host_flags = {i_host_flag_high, i_host_flag_low};

    // Returns the little-endian word at a data offset of the held block.
    function [15:0] blk_word;
        input [5:0] off;
        begin
            blk_word = {blk[off + 6'h03], blk[off + 6'h02]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Host byte stream into the circular buffer.
    // The total-length byte stays out of the ring, so a 64-byte block fits whole.
    cbh_ring u_ring (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_wr(i_host_cmd_wr && host_flags != `CBH_FLAG_END),
        .i_wr_data(i_host_cmd_data),
        .i_rd_back(rd_back),
        .o_rd_data(ring_data),
        .o_head()
    );

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer: host block intake, command effects, response send.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            rd_back <= 6'h00;
            total_len <= 8'h00;
            idx <= 6'h00;
            rsp_len <= 7'h00;
            send_idx <= 7'h00;
            tmo <= 22'h000000;
            tick <= 24'h000000;
            rx_ticks <= 16'h0000;
            rx_limit <= 16'h0000;
            end_seen <= 1'b0;
            host_flags_prev <= 2'h0;
            o_cmd_data <= 8'h00;
            o_host_cmd_full_flag <= 1'b0;
            o_adapter_cmd_empty_flag <= 1'b1;
            o_adapter_flag_low <= 1'b0;
            o_adapter_flag_high <= 1'b0;
            o_host_irq <= 1'b0;
            o_rx_mode <= `CBH_RXMODE_DEFAULT;
            o_cmd_q_entries <= `CBH_DEF_CMD_Q;
            o_rx_q_entries <= `CBH_DEF_RX_Q;
            o_mcast_count <= `CBH_DEF_MCAST;
            o_frame_count <= `CBH_DEF_FRAMES;
            o_rx_buf_count <= `CBH_DEF_RX_BUF;
            o_prog_count <= `CBH_DEF_PROGS;
            o_pkt_buf_bytes <= `CBH_PKT_BUF_BYTES;
            o_tx_buf_count <= `CBH_TX_BUF_COUNT;
            o_xfer_start <= 1'b0;
            o_xfer_upload <= 1'b0;
            o_xfer_dma <= 1'b0;
            o_xfer_count <= 16'h0000;
            o_xfer_error <= 1'b0;
            o_send_abort <= 1'b0;
        end else begin
            o_xfer_start <= 1'b0;
            o_xfer_error <= 1'b0;
            o_send_abort <= 1'b0;
            o_host_irq <= 1'b0;
            host_flags_prev <= host_flags;
            // Host write fills, adapter read in intake empties; set wins.
            if (i_host_cmd_wr) begin
                o_host_cmd_full_flag <= 1'b1;
            end else if (state == ST_IDLE) begin
                o_host_cmd_full_flag <= 1'b0;
            end
            // Host read empties the outgoing register.
            if (i_host_cmd_rd) begin
                o_adapter_cmd_empty_flag <= 1'b1;
            end
            // Remember a length byte written while host flags show end.
            if (i_host_cmd_wr && host_flags == `CBH_FLAG_END) begin
                total_len <= i_host_cmd_data;
                end_seen <= 1'b1;
            end
            // Host leaving its flags idle drops our answer back to idle.
            if (host_flags == `CBH_FLAG_IDLE && host_flags_prev != `CBH_FLAG_IDLE) begin
                {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_IDLE;
            end
            case (state)
                ST_IDLE: begin
                    // Every host write is absorbed; only end of block acts.
                    if (end_seen && host_flags == `CBH_FLAG_END) begin
                        end_seen <= 1'b0;
                        idx <= 6'h00;
                        rd_back <= total_len[5:0];
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // Total length must fit, 2 to 64 bytes; the code+length+data match is checked in ST_ACT.
                    if (total_len > `CBH_MAX_BLOCK || total_len < 8'h02) begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_REJECT;
                        state <= ST_IDLE;
                    end else begin
                        rd_back <= rd_back - 6'h01;
                        state <= ST_PARSE;
                    end
                end
                ST_PARSE: begin
                    // Copy block out of the ring; the code byte was read in the check.
                    rd_back <= rd_back - 6'h01;
                    blk[idx] <= ring_data;
                    idx <= idx + 6'h01;
                    if (idx == total_len[5:0] - 6'h01) begin
                        state <= ST_ACT;
                    end
                end
                ST_ACT: begin
                    if ({2'h0, blk[1]} + 10'h002 != {2'h0, total_len}
                            || blk[1] > `CBH_MAX_DATA) begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_REJECT;
                        state <= ST_IDLE;
                    end else begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_ACCEPT;
                        rsp_len <= 7'h00;
                        state <= ST_HOLD;
                        case (blk[0])
                            `CBH_CMD_CFG_MEM: begin
                                o_cmd_q_entries <= blk_word(6'h00);
                                o_rx_q_entries <= blk_word(6'h02);
                                o_mcast_count <= blk_word(6'h04);
                                o_frame_count <= blk_word(6'h06);
                                o_rx_buf_count <= blk_word(6'h08);
                                o_prog_count <= blk_word(6'h0A);
                                o_pkt_buf_bytes <= `CBH_PKT_BUF_BYTES;
                                o_tx_buf_count <= `CBH_TX_BUF_COUNT;
                                rsp[0] <= `CBH_RSP_CFG_MEM;
                                rsp[1] <= 8'h02;
                                rsp[2] <= 8'h00;
                                rsp[3] <= 8'h00;
                                rsp_len <= 7'h04;
                            end
                            `CBH_CMD_CFG_RX: begin
                                o_rx_mode <= blk[2][4:0];
                                rsp[0] <= `CBH_RSP_CFG_RX;
                                rsp[1] <= 8'h02;
                                rsp[2] <= 8'h00;
                                rsp[3] <= 8'h00;
                                rsp_len <= 7'h04;
                            end
                            `CBH_CMD_STATION: begin
                                rsp[0] <= `CBH_RSP_STATION;
                                rsp[1] <= 8'h06;
                                for (k = 0; k < 6; k = k + 1) begin
                                    rsp[k + 2] <= i_station_addr[8*k +: 8];
                                end
                                rsp_len <= 7'h08;
                            end
                            `CBH_CMD_DL_DMA, `CBH_CMD_DL_PIO,
                            `CBH_CMD_UL_DMA, `CBH_CMD_UL_PIO: begin
                                // Wrong direction or odd count is refused.
                                if (i_dir != blk[0][0] || blk[2][0]) begin
                                    o_xfer_error <= 1'b1;
                                end else begin
                                    o_xfer_start <= 1'b1;
                                    o_xfer_upload <= blk[0][0];
                                    o_xfer_dma <= ~blk[0][1];
                                    o_xfer_count <= blk_word(6'h00);
                                end
                            end
                            `CBH_CMD_RECEIVE: begin
                                rx_limit <= blk_word(6'h06) & `CBH_RX_TICK_MAX;
                                rx_ticks <= 16'h0000;
                                tick <= 24'h000000;
                                state <= ST_WAIT_PKT;
                            end
                            `CBH_CMD_TRANSMIT: begin
                                // Host download of the packet begins now.
                                o_xfer_start <= 1'b1;
                                o_xfer_upload <= 1'b0;
                                o_xfer_dma <= 1'b1;
                                o_xfer_count <= blk_word(6'h04);
                                state <= ST_WAIT_PKT;
                            end
                            default: begin
                                rsp_len <= 7'h00;
                            end
                        endcase
                    end
                end
                ST_WAIT_PKT: begin
                    // Packet arrival or transmit end builds the response.
                    if (blk[0] == `CBH_CMD_RECEIVE && i_pkt_rx) begin
                        rsp[0] <= `CBH_RSP_RECEIVE;
                        rsp[1] <= 8'h02;
                        rsp[2] <= 8'h00;
                        rsp[3] <= 8'h00;
                        rsp_len <= 7'h04;
                        o_xfer_start <= 1'b1;
                        o_xfer_upload <= 1'b1;
                        o_xfer_dma <= 1'b1;
                        o_xfer_count <= blk_word(6'h04);
                        state <= ST_HOLD;
                    end else if (blk[0] == `CBH_CMD_RECEIVE && rx_limit != 16'h0000
                            && rx_ticks == rx_limit) begin
                        rsp[0] <= `CBH_RSP_RECEIVE;
                        rsp[1] <= 8'h02;
                        rsp[2] <= 8'hFF;
                        rsp[3] <= 8'hFF;
                        rsp_len <= 7'h04;
                        state <= ST_HOLD;
                    end else if (blk[0] == `CBH_CMD_TRANSMIT && i_tx_done) begin
                        rsp[0] <= `CBH_RSP_TRANSMIT;
                        rsp[1] <= 8'h02;
                        rsp[2] <= 8'h00;
                        rsp[3] <= 8'h00;
                        rsp_len <= 7'h04;
                        state <= ST_HOLD;
                    end
                    // Ten millisecond tick count for the receive timeout.
                    if (tick == `CBH_TICK_CYC - 1) begin
                        tick <= 24'h000000;
                        rx_ticks <= rx_ticks + 16'h0001;
                    end else begin
                        tick <= tick + 24'h000001;
                    end
                end
                ST_HOLD: begin
                    // Wait for host to drop its end flags, then send if any.
                    if (host_flags != `CBH_FLAG_END) begin
                        send_idx <= 7'h00;
                        state <= (rsp_len == 7'h00) ? ST_IDLE : ST_SEND;
                    end
                end
                ST_SEND: begin
                    // Write next byte; the length byte goes out with the end flags.
                    if (send_idx == rsp_len) begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_END;
                        o_cmd_data <= {1'b0, rsp_len};
                    end else begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_IDLE;
                        o_cmd_data <= rsp[send_idx[5:0]];
                    end
                    o_adapter_cmd_empty_flag <= 1'b0;
                    o_host_irq <= (send_idx == 7'h00);
                    tmo <= 22'h000000;
                    state <= ST_SEND_WAIT;
                end
                ST_SEND_WAIT: begin
                    // First byte gets 20 ms, every later byte 500 us.
                    if (o_adapter_cmd_empty_flag || i_host_cmd_rd) begin
                        if (send_idx == rsp_len) begin
                            state <= ST_HOST_ANS;
                        end else begin
                            send_idx <= send_idx + 7'h01;
                            state <= ST_SEND;
                        end
                    end else if ((send_idx == 7'h00 && tmo == `CBH_FIRST_TMO_CYC - 1)
                            || (send_idx != 7'h00 && tmo == `CBH_NEXT_TMO_CYC - 1)) begin
                        o_send_abort <= 1'b1;
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_IDLE;
                        state <= ST_IDLE;
                    end else begin
                        tmo <= tmo + 22'h000001;
                    end
                end
                ST_HOST_ANS: begin
                    // Host answers our end of block with accept or reject.
                    if (host_flags == `CBH_FLAG_ACCEPT || host_flags == `CBH_FLAG_REJECT) begin
                        {o_adapter_flag_high, o_adapter_flag_low} <= `CBH_FLAG_IDLE;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// File: hdl/cbh_ring.v
/*
 * Sixty-four byte circular buffer holding the incoming host byte stream.
 * Assumes the writer never needs more than the last 64 bytes kept.
 */
`timescale 1ns/10ps
`include "cbh_defines.vh"

module cbh_ring (
    // Clock and reset.
    input wire i_clk,
    input wire i_reset_n,
    // Write side.
    input wire i_wr,
    input wire [7:0] i_wr_data,
    // Read side, addressed back from the head, the slot after the newest byte.
    input wire [5:0] i_rd_back,
    output reg [7:0] o_rd_data,
    output reg [5:0] o_head
);

    reg [7:0] mem [0:`CBH_RING_DEPTH-1];

    ////////////////////////////////////////////////////////////////////////
    // Store bytes and wrap the head; the oldest byte is overwritten.
    always @(posedge i_clk) begin
        if (i_wr) begin
            mem[o_head] <= i_wr_data;
        end
        o_rd_data <= mem[o_head - i_rd_back];
    end

    // Head pointer.
    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_head <= 6'h00;
        end else if (i_wr) begin
            o_head <= o_head + 6'h01;
        end
    end

endmodule

// File: pkg/cbh_defines.vh
/*
 * Constants for the command block handshake: flag codes, command and
 * response codes, buffer sizes, configuration defaults and timeouts.
 * Assumes a 100 MHz core clock; counts are derived from times in ns.
 */
`ifndef CBH_DEFINES_VH
`define CBH_DEFINES_VH

// Status flag pair encodings.
`define CBH_FLAG_IDLE 2'h0
`define CBH_FLAG_ACCEPT 2'h1
`define CBH_FLAG_REJECT 2'h2
`define CBH_FLAG_END 2'h3

// Block sizes.
`define CBH_RING_DEPTH 64
`define CBH_RING_AW 6
`define CBH_MAX_DATA 8'h3E
`define CBH_MAX_BLOCK 8'h40

// Host command codes.
`define CBH_CMD_CFG_MEM 8'h01
`define CBH_CMD_CFG_RX 8'h02
`define CBH_CMD_STATION 8'h03
`define CBH_CMD_DL_DMA 8'h04
`define CBH_CMD_UL_DMA 8'h05
`define CBH_CMD_DL_PIO 8'h06
`define CBH_CMD_UL_PIO 8'h07
`define CBH_CMD_RECEIVE 8'h08
`define CBH_CMD_TRANSMIT 8'h09

// Response codes.
`define CBH_RSP_CFG_MEM 8'h31
`define CBH_RSP_CFG_RX 8'h32
`define CBH_RSP_STATION 8'h33
`define CBH_RSP_RECEIVE 8'h38
`define CBH_RSP_TRANSMIT 8'h39

// Memory configuration defaults.
`define CBH_DEF_CMD_Q 16'h000A
`define CBH_DEF_RX_Q 16'h0014
`define CBH_DEF_MCAST 16'h0000
`define CBH_DEF_FRAMES 16'h0014
`define CBH_DEF_RX_BUF 16'h0014
`define CBH_DEF_PROGS 16'h000A
`define CBH_PKT_BUF_BYTES 16'h0640
`define CBH_TX_BUF_COUNT 8'h01

// Receive mode fields and default.
`define CBH_RXMODE_DEFAULT 5'h00
`define CBH_RXMODE_FILT_LSB 0
`define CBH_RXMODE_LOOP_LSB 3
`define CBH_RX_TICK_MAX 16'h7FFF

// Times in ns and the derived cycle counts at a 10 ns clock.
`define CBH_CLK_NS 10
`define CBH_FIRST_TMO_NS 20000000
`define CBH_NEXT_TMO_NS 500000
`define CBH_TICK_NS 10000000
`define CBH_FIRST_TMO_CYC (`CBH_FIRST_TMO_NS / `CBH_CLK_NS)
`define CBH_NEXT_TMO_CYC (`CBH_NEXT_TMO_NS / `CBH_CLK_NS)
`define CBH_TICK_CYC (`CBH_TICK_NS / `CBH_CLK_NS)

`endif
